// [pkg/cml_pkg.sv]
// Package: constants and types for the configuration menu access lock
`default_nettype none
package cml_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam logic [11:0] ADDR_INDEX = 12'h00C;
  localparam logic [11:0] ADDR_DISP = 12'h010;
  // CTRL fields (write one to act)
  localparam int CTRL_TOTAL_RESET = 0;
  localparam int CTRL_INTEGRATION = 1;
  // STATUS fields
  localparam int ST_SHIPPING = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_IN_MENU = 2;
  localparam int ST_LIMIT = 3;
  localparam int ST_COMMIT = 4;
  localparam int ST_EXIT_LO = 5;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 40000000;
  localparam longint ENTRY_HOLD_S = 9;
  localparam longint END_HOLD_S = 5;
  localparam longint TIMEOUT_MIN = 4;
  localparam longint ENTRY_HOLD_CYC = ENTRY_HOLD_S * CLK_HZ;
  localparam longint END_HOLD_CYC = END_HOLD_S * CLK_HZ;
  localparam longint TIMEOUT_CYC = TIMEOUT_MIN * 60 * CLK_HZ;
  localparam logic [4:0] CONFIG_LIMIT = 5'h19;
  // Display indices: loop 2, item, sub (BCD digits)
  localparam logic [11:0] IDX_INFO = 12'h010;
  localparam logic [11:0] IDX_CUST = 12'h011;
  localparam logic [11:0] IDX_COMM = 12'h101;
  localparam logic [7:0] SUB_SEG_TEST = 8'h21;
  localparam logic [7:0] SUB_COMM_LAST = 8'h03;
  localparam logic [7:0] SUB_INFO_LAST = 8'h03;
  localparam logic [7:0] SUB_CUST_LAST = 8'h21;
  // Exit causes
  typedef enum logic [1:0] {
    CML_EXIT_NONE = 2'b00,
    CML_EXIT_KEY = 2'b01,
    CML_EXIT_TIMEOUT = 2'b10,
    CML_EXIT_END = 2'b11
  } cml_exit_t;
  typedef enum logic [1:0] {
    CML_ST_DISPLAY = 2'b00,
    CML_ST_ARMED = 2'b01,
    CML_ST_MENU = 2'b10
  } cml_state_t;
  typedef struct packed {
    logic [3:0] loop;
    logic [11:0] item;
    logic [7:0] sub;
  } cml_index_t;
endpackage
`default_nettype wire

// [hdl/cml_menu_lock.sv]
// Menu access lock, exit detection and service display index stepping
// Notes on behaviour
// - Count sessions; after 25 refuse menu entry until total reset.
// - Shipping and unlocked: entry allowed without shorted service contacts.
// - Shipping state ends at first integration or end-configuration exit.
// - Only total reset restores the shipping state.
// - After commissioning, entry needs the seal broken and contacts shorted.
// - Long key hold leaves the menu, in every state.
// - Four minutes in menu times out, back to first primary reading.
// - End item held five seconds exits and sets the lock.
// - Shipping: key or timeout exit keep access; end exit locks.
// - After commissioning every exit locks access.
// - Communication config at 2-101, subs 01 to 03.
// - Min/max shown as date only, 20xx.xx.xx format.
// - Temperature averages are volume weighted.
// - Logger positions past configured depth show empty; here only info sub 03 shows empty, and only when YEAR_DEPTH is 0.
// - Key held 9 seconds from primary loop enters the menu.
// - Unit and resolution changes commit only on menu exit.
`default_nettype none
module cml_menu_lock #(
  parameter longint ENTRY_HOLD = cml_pkg::ENTRY_HOLD_CYC,
  parameter longint END_HOLD = cml_pkg::END_HOLD_CYC,
  parameter longint MENU_TIMEOUT = cml_pkg::TIMEOUT_CYC,
  parameter int YEAR_DEPTH = 2,
  parameter int MONTH_DEPTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key,
  input wire logic service_short,
  input wire logic on_end_item,
  input wire logic key_tap,
  output logic in_menu,
  output logic commit_codes,
  output logic return_first,
  output cml_pkg::cml_index_t disp_index,
  output logic disp_empty
);
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic wr, rd_ok;
  logic total_reset, integration;
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb begin
    rd_ok = 1'b1;
    if (paddr == cml_pkg::ADDR_CTRL) begin
      rd_ok = 1'b1;
    end else if (paddr == cml_pkg::ADDR_STATUS) begin
      rd_ok = 1'b1;
    end else if (paddr == cml_pkg::ADDR_COUNT) begin
      rd_ok = 1'b1;
    end else if (paddr == cml_pkg::ADDR_INDEX) begin
      rd_ok = 1'b1;
    end else if (paddr == cml_pkg::ADDR_DISP) begin
      rd_ok = 1'b1;
    end else begin
      rd_ok = 1'b0;
    end
  end
  assign pslverr = psel && penable && !rd_ok;
  assign total_reset = wr && paddr == cml_pkg::ADDR_CTRL && pwdata[cml_pkg::CTRL_TOTAL_RESET];
  assign integration = wr && paddr == cml_pkg::ADDR_CTRL && pwdata[cml_pkg::CTRL_INTEGRATION];

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  // 64-bit counters keep the full 4-minute count without overflow hazards
  logic [63:0] hold_cnt, menu_cnt;
  logic shipping, locked, menu_now;
  logic [4:0] sessions;
  cml_pkg::cml_state_t state;
  cml_pkg::cml_exit_t exit_cause, last_exit;
  logic limit_hit, may_enter, entry_hit, end_hit, timeout_hit, key_exit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 64'h0;
    end else if (key) begin
      hold_cnt <= hold_cnt + 64'h1;
    end else begin
      hold_cnt <= 64'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_cnt <= 64'h0;
    end else if (state != cml_pkg::CML_ST_MENU) begin
      menu_cnt <= 64'h0;
    end else begin
      menu_cnt <= menu_cnt + 64'h1;
    end
  end

  assign limit_hit = sessions >= cml_pkg::CONFIG_LIMIT;
  // Shipping and unlocked needs no contacts; otherwise contacts must be shorted
  assign may_enter = !limit_hit && ((shipping && !locked) || service_short);
  assign entry_hit = state == cml_pkg::CML_ST_DISPLAY && key
    && hold_cnt == 64'(ENTRY_HOLD - 1) && may_enter;
  assign end_hit = menu_now && on_end_item && key && hold_cnt == 64'(END_HOLD - 1);
  assign timeout_hit = menu_now && menu_cnt == 64'(MENU_TIMEOUT - 1);
  // Long hold off a non-end item navigates away
  assign key_exit = menu_now && !on_end_item && key && hold_cnt == 64'(ENTRY_HOLD - 1);
  assign menu_now = state == cml_pkg::CML_ST_MENU;

  always_comb begin
    exit_cause = cml_pkg::CML_EXIT_NONE;
    if (end_hit) begin
      exit_cause = cml_pkg::CML_EXIT_END;
    end else if (key_exit) begin
      exit_cause = cml_pkg::CML_EXIT_KEY;
    end else if (timeout_hit) begin
      exit_cause = cml_pkg::CML_EXIT_TIMEOUT;
    end
  end

  // ------------------------------------------------------------
  // Menu state
  // ------------------------------------------------------------
  // Banner is armed at the hold threshold; the menu opens on key release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cml_pkg::CML_ST_DISPLAY;
    end else begin
      case (state)
        cml_pkg::CML_ST_DISPLAY: begin
          if (entry_hit) begin
            state <= cml_pkg::CML_ST_ARMED;
          end
        end
        cml_pkg::CML_ST_ARMED: begin
          if (!key) begin
            state <= cml_pkg::CML_ST_MENU;
          end
        end
        cml_pkg::CML_ST_MENU: begin
          if (exit_cause != cml_pkg::CML_EXIT_NONE) begin
            state <= cml_pkg::CML_ST_DISPLAY;
          end
        end
        default: begin
          state <= cml_pkg::CML_ST_DISPLAY;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shipping <= 1'b1;
    end else if (total_reset) begin
      shipping <= 1'b1;
    end else if (integration || exit_cause == cml_pkg::CML_EXIT_END) begin
      shipping <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
    end else if (exit_cause == cml_pkg::CML_EXIT_END) begin
      locked <= 1'b1;
    end else if (exit_cause != cml_pkg::CML_EXIT_NONE && !shipping) begin
      locked <= 1'b1;
    end else if (total_reset) begin
      // A lock set by an exit in the same cycle wins over the clear
      locked <= 1'b0;
    end else if (!shipping && locked && entry_hit) begin
      locked <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sessions <= 5'h00;
    end else if (total_reset) begin
      sessions <= 5'h00;
    end else if (exit_cause != cml_pkg::CML_EXIT_NONE && !limit_hit) begin
      sessions <= sessions + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_exit <= cml_pkg::CML_EXIT_NONE;
      commit_codes <= 1'b0;
      return_first <= 1'b0;
    end else begin
      commit_codes <= exit_cause != cml_pkg::CML_EXIT_NONE;
      return_first <= exit_cause == cml_pkg::CML_EXIT_TIMEOUT;
      if (exit_cause != cml_pkg::CML_EXIT_NONE) begin
        last_exit <= exit_cause;
      end
    end
  end
  assign in_menu = menu_now;

  // ------------------------------------------------------------
  // Service display loop index
  // ------------------------------------------------------------
  // Only the groups this block numbers are stepped; others stay at item
  function automatic logic [7:0] sub_last(input logic [11:0] item);
    if (item == cml_pkg::IDX_INFO) begin
      sub_last = cml_pkg::SUB_INFO_LAST;
    end else if (item == cml_pkg::IDX_CUST) begin
      sub_last = cml_pkg::SUB_CUST_LAST;
    end else begin
      sub_last = cml_pkg::SUB_COMM_LAST;
    end
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_index <= '{loop: 4'h2, item: cml_pkg::IDX_INFO, sub: 8'h00};
    end else if (key_tap && !menu_now) begin
      if (disp_index.sub == sub_last(disp_index.item)) begin
        disp_index.sub <= 8'h00;
        if (disp_index.item == cml_pkg::IDX_INFO) begin
          disp_index.item <= cml_pkg::IDX_CUST;
        end else if (disp_index.item == cml_pkg::IDX_CUST) begin
          disp_index.item <= cml_pkg::IDX_COMM;
        end else begin
          disp_index.item <= cml_pkg::IDX_INFO;
        end
      end else begin
        disp_index.sub <= bcd_inc(disp_index.sub);
      end
    end
  end

  // Info item sub 03 shows a blank position only when YEAR_DEPTH is 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_empty <= 1'b0;
    end else begin
      disp_empty <= disp_index.item == cml_pkg::IDX_INFO
        && disp_index.sub == 8'h03 && YEAR_DEPTH == 0;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // concern value formatting upstream; no datapath lives here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == cml_pkg::ADDR_STATUS) begin
        prdata <= {25'h0, last_exit, commit_codes, limit_hit, menu_now, locked, shipping};
      end else if (paddr == cml_pkg::ADDR_COUNT) begin
        prdata <= {27'h0, sessions};
      end else if (paddr == cml_pkg::ADDR_INDEX) begin
        prdata <= {8'h0, disp_index};
      end else if (paddr == cml_pkg::ADDR_DISP) begin
        prdata <= {30'h0, disp_empty, return_first};
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/cml_menu_lock_asserts.sv]
// Checker for the menu lock port relations
`default_nettype none
module cml_menu_lock_asserts #(
  parameter longint ENTRY_HOLD = 20,
  parameter longint MENU_TIMEOUT = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic key,
  input wire logic in_menu,
  input wire logic commit_codes,
  input wire logic return_first
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  int run;
  int last;
  int dwell;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 0;
      last <= 0;
    end else begin
      run <= key ? run + 1 : 0;
      if (!key && run != 0) last <= run;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dwell <= 0;
    else dwell <= in_menu ? dwell + 1 : 0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr[1:0] == 2'h0 &&
    paddr <= 12'h010 |-> !pslverr) else $error("mapped access refused");
  entry_hold_a: assert property ($rose(in_menu) |->
    last >= ENTRY_HOLD || run >= ENTRY_HOLD) else $error("entry without long hold");
  commit_exit_a: assert property ($fell(in_menu) |-> ##[0:1] commit_codes)
    else $error("no commit on exit");
  commit_cause_a: assert property ($rose(commit_codes) |-> !in_menu)
    else $error("commit inside menu");
  return_pair_a: assert property (return_first |-> commit_codes && !in_menu)
    else $error("return pulse without exit");
  menu_timeout_a: assert property (dwell <= MENU_TIMEOUT + 2)
    else $error("menu stayed past timeout");
  cover property ($rose(in_menu));
  cover property (return_first);
  cover property ($rose(pslverr));
endmodule
`default_nettype wire

// [tb/cml_tech_model.sv]
// Technician model: front key, service contacts and end item
`default_nettype none
module cml_tech_model (
  input wire logic pclk,
  output logic key,
  output logic service_short,
  output logic on_end_item,
  output logic key_tap
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key = 1'b0;
    service_short = 1'b0;
    on_end_item = 1'b0;
    key_tap = 1'b0;
  end
  // Long press held a set number of cycles
  task automatic hold(input int n);
    @(posedge pclk);
    key <= 1'b1;
    repeat (n) @(posedge pclk);
    key <= 1'b0;
  endtask
  // Contacts under the seal are shorted only while commanded
  task automatic set_short(input logic v);
    @(posedge pclk);
    service_short <= v;
  endtask
  task automatic set_end(input logic v);
    @(posedge pclk);
    on_end_item <= v;
  endtask
  // Brief presses, one clock each, step the service display loop
  task automatic tap(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      key_tap <= 1'b1;
      @(posedge pclk);
      key_tap <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [tb/cml_menu_lock_tb_top.sv]
// Testbench for the menu access lock
`default_nettype none
module cml_menu_lock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts so the run stays brief
  localparam int ENT = 20;
  localparam int HOLD = ENT + 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, key, service_short, on_end_item, key_tap;
  logic in_menu, commit_codes, return_first, disp_empty;
  cml_pkg::cml_index_t disp_index;
  int error_cnt = 0;
  int comparisons = 0;
  int ret_cnt = 0;
  int commit_cnt = 0;
  always #12.5 pclk = ~pclk;
  cml_tech_model cml_tech_model_i (.pclk(pclk), .key(key), .service_short(service_short),
    .on_end_item(on_end_item), .key_tap(key_tap));
  cml_menu_lock #(.ENTRY_HOLD(ENT), .END_HOLD(10), .MENU_TIMEOUT(50),
    .YEAR_DEPTH(0)) cml_menu_lock_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key(key), .service_short(service_short), .on_end_item(on_end_item),
    .key_tap(key_tap), .in_menu(in_menu), .commit_codes(commit_codes),
    .return_first(return_first), .disp_index(disp_index), .disp_empty(disp_empty));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pulse counters for the exit side effects
  always @(posedge pclk) begin
    if (return_first === 1'b1) begin
      ret_cnt <= ret_cnt + 1;
    end
    if (commit_codes === 1'b1) begin
      commit_cnt <= commit_cnt + 1;
    end
  end
  task automatic wait_in(input logic v);
    for (int i = 0; i < 60 && in_menu !== v; i++) @(posedge pclk);
    check(in_menu, v);
  endtask
  task automatic finish_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h1);
    check(disp_index, 24'h201000);
    cml_tech_model_i.tap(3);
    repeat (2) @(posedge pclk);
    check(disp_index, 24'h201003);
    apb(1'b0, cml_pkg::ADDR_DISP, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, cml_pkg::ADDR_INDEX, 32'h0);
    check(rd, 32'h00201003);
    cml_tech_model_i.tap(22);
    repeat (2) @(posedge pclk);
    check(disp_index, 24'h201121);
    cml_tech_model_i.tap(4);
    repeat (2) @(posedge pclk);
    check(disp_index, 24'h210103);
    cml_tech_model_i.tap(1);
    repeat (2) @(posedge pclk);
    check(disp_index, 24'h201000);
    apb(1'b0, cml_pkg::ADDR_DISP, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b1);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b0);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b1);
    repeat (49) @(posedge pclk);
    check(in_menu, 1'b1);
    @(posedge pclk);
    check(in_menu, 1'b0);
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h1);
    check(ret_cnt, 1);
    check(commit_cnt, 2);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b1);
    cml_tech_model_i.set_end(1'b1);
    cml_tech_model_i.hold(12);
    wait_in(1'b0);
    cml_tech_model_i.set_end(1'b0);
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h2);
    cml_tech_model_i.hold(HOLD);
    repeat (5) @(posedge pclk);
    check(in_menu, 1'b0);
    cml_tech_model_i.set_short(1'b1);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b1);
    cml_tech_model_i.set_short(1'b0);
    cml_tech_model_i.hold(HOLD);
    wait_in(1'b0);
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h2);
    apb(1'b0, cml_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h4);
    check(commit_cnt, 4);
    apb(1'b1, cml_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h1);
    apb(1'b1, cml_pkg::ADDR_CTRL, 32'h2);
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'h1, 32'h0);
    apb(1'b1, cml_pkg::ADDR_CTRL, 32'h1);
    for (int s = 0; s < 25; s++) begin
      cml_tech_model_i.hold(HOLD);
      wait_in(1'b1);
      cml_tech_model_i.hold(HOLD);
      wait_in(1'b0);
    end
    cml_tech_model_i.set_short(1'b1);
    cml_tech_model_i.hold(HOLD);
    repeat (5) @(posedge pclk);
    check(in_menu, 1'b0);
    cml_tech_model_i.set_short(1'b0);
    apb(1'b0, cml_pkg::ADDR_COUNT, 32'h0);
    check(rd, {27'h0, cml_pkg::CONFIG_LIMIT});
    apb(1'b0, cml_pkg::ADDR_STATUS, 32'h0);
    check(rd & 32'hB, 32'h9);
    apb(1'b1, cml_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, cml_pkg::ADDR_COUNT, 32'h0);
    check(rd, 32'h0);
    check(commit_cnt, 29);
    check(ret_cnt, 1);
    finish_test;
  end
endmodule
bind cml_menu_lock cml_menu_lock_asserts #(.ENTRY_HOLD(ENTRY_HOLD),
  .MENU_TIMEOUT(MENU_TIMEOUT)) cml_menu_lock_asserts_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .key(key), .in_menu(in_menu), .commit_codes(commit_codes),
  .return_first(return_first));
`default_nettype wire
